//--- iwhc_pkg.sv
// Constants for the interrupt, watchdog and halt supervisor.
// Assumes one 50 MHz system clock and a synchronous active-high reset.
package iwhc_pkg;
  localparam logic [7:0] INTC_LOW_ADDR = 8'h0b;
  localparam logic [7:0] INTC_HIGH_ADDR = 8'h1e;
  localparam logic [7:0] INTC_RESET = 8'h00;
  // Source order in the internal vectors: external, timer, converter, serial bus
  localparam int SRC_EXT = 0;
  localparam int SRC_TMR = 1;
  localparam int SRC_CONV = 2;
  localparam int SRC_SER = 3;
  localparam int LOW_GIE_BIT = 0;
  localparam int LOW_EN_LSB = 1;
  localparam int LOW_FLAG_LSB = 4;
  localparam int HIGH_EN_BIT = 0;
  localparam int HIGH_FLAG_BIT = 4;
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_TMR = 8'h08;
  localparam logic [7:0] VEC_CONV = 8'h0c;
  localparam logic [7:0] VEC_SER = 8'h10;
  localparam logic [3:0][7:0] VECTORS = {VEC_SER, VEC_CONV, VEC_TMR, VEC_EXT};
  // Wake-up settling delay in system clocks
  localparam logic [10:0] STARTUP_CYCLES = 11'h400;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam int WDT_CNT_W = 17;
  localparam int WDT_BASE_STAGES = 12;
  // Pin vector: port A [7:0], external interrupt 8, reset pin 9, watchdog oscillator 10
  localparam int PIN_W = 11;
  localparam int PIN_EXT_INT = 8;
  localparam int PIN_RESET = 9;
  localparam int PIN_WDT_OSC = 10;
  localparam logic [10:0] PIN_IDLE = 11'h3ff;
  typedef enum logic [1:0] {IWHC_RUN, IWHC_HALT, IWHC_START} iwhc_state_t;
endpackage

//--- iwhc_guard.sv
// Watchdog counter with full clear and last-stage clear.
// Assumes the tick input is already qualified by source, enable and halt.
`timescale 1ns/100ps
`default_nettype none
module iwhc_guard import iwhc_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic [1:0] ratio_i,
  input wire logic full_clear_i,
  input wire logic stage_clear_i,
  output logic overflow_o
);
  logic [WDT_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic ovf_ff, nxt_ovf;
  logic [WDT_CNT_W-1:0] top, low_mask;

  function automatic logic [WDT_CNT_W-1:0] stage_bit(input logic [1:0] r, input logic [1:0] add);
    stage_bit = WDT_CNT_W'(1) << (WDT_BASE_STAGES + int'(r) + int'(add));
  endfunction

  always_comb begin
    top = stage_bit(ratio_i, 2'd1);
    low_mask = stage_bit(ratio_i, 2'd0) - WDT_CNT_W'(1);
    nxt_cnt = cnt_ff;
    nxt_ovf = 1'b0;
    if (full_clear_i) begin
      nxt_cnt = '0;
    end else if (stage_clear_i) begin
      nxt_cnt = cnt_ff & low_mask;
    end else if (tick_i) begin
      if (cnt_ff == top - WDT_CNT_W'(1)) begin
        nxt_cnt = '0;
        nxt_ovf = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + WDT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_ff <= '0;
      ovf_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ovf_ff <= nxt_ovf;
    end
  end
  assign overflow_o = ovf_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_stage_clear_bound: assert property (stage_clear_i && !full_clear_i |=> cnt_ff <= low_mask)
    else $error("stage clear left upper stages set");
  a_ovf_from_top: assert property (overflow_o |-> $past(tick_i) && $past(cnt_ff) == top - WDT_CNT_W'(1))
    else $error("overflow without reaching the selected ratio");
  a_full_clear_zero: assert property (full_clear_i |=> cnt_ff == '0 && !overflow_o)
    else $error("full clear did not zero the counter");
endmodule
`default_nettype wire

//--- iwhc_top.sv
// Interrupt flags and vectoring, watchdog control, halt and wake-up sequencing.
// Assumes core strobes are one-cycle pulses on clk_i; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module iwhc_top import iwhc_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rd_data_o,
  input wire logic second_phase_clock_i,
  input wire logic stack_full_i,
  input wire logic return_from_interrupt_i,
  input wire logic halt_exec_i,
  input wire logic single_guard_clear_i,
  input wire logic first_guard_clear_i,
  input wire logic second_guard_clear_i,
  input wire logic timer_overflow_i,
  input wire logic converter_done_i,
  input wire logic own_address_matched_i,
  input wire logic byte_done_i,
  input wire logic external_int_n_i,
  input wire logic external_reset_pin_n_i,
  input wire logic [7:0] port_a_i,
  input wire logic guard_osc_i,
  input wire logic opt_rc_osc_i,
  input wire logic opt_guard_enable_i,
  input wire logic opt_guard_src_osc_i,
  input wire logic opt_guard_osc_enable_i,
  input wire logic [1:0] opt_guard_ratio_i,
  input wire logic opt_two_clear_i,
  input wire logic [7:0] opt_port_wake_i,
  output logic int_call_o,
  output logic [7:0] int_vector_o,
  output logic running_o,
  output logic halted_o,
  output logic chip_reset_o,
  output logic warm_reset_o,
  output logic oscillator_pin_two_o,
  output logic timeout_flag_o,
  output logic power_down_flag_o
);
  logic [PIN_W-1:0] sy1_ff, sy2_ff, sy3_ff, flt_ff, nxt_flt, pin_raw, fall, rise;
  logic [3:0] flags_ff, nxt_flags, en_ff, nxt_en, mask_ff, nxt_mask, events, pend;
  logic gie_ff, nxt_gie, seen1_ff, nxt_seen1, seen2_ff, nxt_seen2;
  logic to_ff, nxt_to, pdf_ff, nxt_pdf, call_ff, nxt_call, crst_ff, nxt_crst;
  logic warm_ff, nxt_warm, run_ff, nxt_run, halt_ff, nxt_halt, oscillator_pin_two_ff, nxt_oscillator_pin_two;
  logic [7:0] vec_ff, nxt_vec, rd_ff, nxt_rd;
  logic [10:0] scnt_ff, nxt_scnt;
  logic [1:0] div_ff, nxt_div, pick;
  iwhc_state_t state_ff, nxt_state;
  logic rst_low, ack, halt_entry, guard_clear, wake, ovf, tick, wr_low, wr_high;

  function automatic logic [1:0] iwhc_pick(input logic [3:0] req);
    iwhc_pick = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        iwhc_pick = 2'(i);
      end
    end
  endfunction

  // Pin synchronisers; a change counts once stages two and three agree
  assign pin_raw = {guard_osc_i, external_reset_pin_n_i, external_int_n_i, port_a_i};
  generate
    for (genvar g = 0; g < PIN_W; g++) begin : g_pin
      assign nxt_flt[g] = (sy2_ff[g] == sy3_ff[g]) ? sy3_ff[g] : flt_ff[g];
      assign fall[g] = flt_ff[g] & ~nxt_flt[g];
      assign rise[g] = ~flt_ff[g] & nxt_flt[g];
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sy1_ff <= PIN_IDLE;
      sy2_ff <= PIN_IDLE;
      sy3_ff <= PIN_IDLE;
      flt_ff <= PIN_IDLE;
    end else begin
      sy1_ff <= pin_raw;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      flt_ff <= nxt_flt;
    end
  end

  assign rst_low = ~flt_ff[PIN_RESET];
  // Instruction clock stops with the system oscillator in halt; own oscillator keeps going
  assign tick = opt_guard_enable_i & (opt_guard_src_osc_i ?
                (rise[PIN_WDT_OSC] & opt_guard_osc_enable_i) :
                (div_ff == INSTR_DIV_LAST && state_ff != IWHC_HALT));
  assign halt_entry = halt_exec_i && state_ff == IWHC_RUN;

  iwhc_guard u_guard (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .ratio_i(opt_guard_ratio_i),
    .full_clear_i(rst_low | halt_entry),
    .stage_clear_i(guard_clear),
    .overflow_o(ovf)
  );

  assign events = {own_address_matched_i | byte_done_i, converter_done_i,
                   timer_overflow_i, fall[PIN_EXT_INT]};
  assign pend = flags_ff & en_ff;
  assign pick = iwhc_pick(pend);
  assign ack = state_ff == IWHC_RUN && second_phase_clock_i && gie_ff &&
               !stack_full_i && |pend;
  assign wr_low = wr_en_i && addr_i == INTC_LOW_ADDR;
  assign wr_high = wr_en_i && addr_i == INTC_HIGH_ADDR;
  assign wake = |(flags_ff & ~mask_ff) || |(fall[7:0] & opt_port_wake_i);

  always_comb begin
    nxt_flags = flags_ff;
    nxt_en = en_ff;
    nxt_gie = gie_ff;
    nxt_mask = mask_ff;
    nxt_call = 1'b0;
    nxt_vec = vec_ff;
    nxt_seen1 = seen1_ff;
    nxt_seen2 = seen2_ff;
    guard_clear = 1'b0;
    if (wr_low) begin
      nxt_gie = wdata_i[LOW_GIE_BIT];
      nxt_en[2:0] = wdata_i[LOW_EN_LSB +: 3];
      nxt_flags[2:0] = wdata_i[LOW_FLAG_LSB +: 3];
    end
    if (wr_high) begin
      nxt_en[SRC_SER] = wdata_i[HIGH_EN_BIT];
      nxt_flags[SRC_SER] = wdata_i[HIGH_FLAG_BIT];
    end
    if (ack) begin
      nxt_flags[pick] = 1'b0;
      nxt_gie = 1'b0;
      nxt_call = 1'b1;
      nxt_vec = VECTORS[pick];
    end
    // Plain subroutine return has no port here and never touches the global enable
    if (return_from_interrupt_i) begin
      nxt_gie = 1'b1;
    end
    nxt_flags = nxt_flags | events;
    if (halt_entry) begin
      nxt_mask = flags_ff;
    end
    // Clear instructions act only when the watchdog option is on
    if (opt_guard_enable_i) begin
      if (!opt_two_clear_i) begin
        guard_clear = single_guard_clear_i;
      end else begin
        nxt_seen1 = seen1_ff | first_guard_clear_i;
        nxt_seen2 = seen2_ff | second_guard_clear_i;
        guard_clear = nxt_seen1 & nxt_seen2;
        if (guard_clear) begin
          nxt_seen1 = 1'b0;
          nxt_seen2 = 1'b0;
        end
      end
    end
    if (rst_low || (ovf && state_ff != IWHC_HALT)) begin
      nxt_flags = INTC_RESET[3:0];
      nxt_en = INTC_RESET[3:0];
      nxt_gie = 1'b0;
      nxt_seen1 = 1'b0;
      nxt_seen2 = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_scnt = scnt_ff;
    nxt_to = to_ff;
    nxt_pdf = pdf_ff;
    nxt_crst = 1'b0;
    nxt_warm = 1'b0;
    nxt_div = (state_ff == IWHC_HALT) ? div_ff : div_ff + 2'd1;
    nxt_oscillator_pin_two = opt_rc_osc_i & nxt_div[1];
    if (guard_clear) begin
      nxt_pdf = 1'b0;
      nxt_to = 1'b0;
    end
    case (state_ff)
      IWHC_RUN: begin
        if (halt_entry) begin
          nxt_state = IWHC_HALT;
          nxt_pdf = 1'b1;
          nxt_to = 1'b0;
        end
      end
      IWHC_HALT: begin
        if (rst_low || ovf || wake) begin
          nxt_state = IWHC_START;
          nxt_scnt = '0;
        end
      end
      IWHC_START: begin
        if (!rst_low) begin
          nxt_scnt = scnt_ff + 11'd1;
          if (scnt_ff == STARTUP_CYCLES - 11'd1) begin
            nxt_state = IWHC_RUN;
          end
        end
      end
      default: nxt_state = IWHC_START;
    endcase
    if (ovf) begin
      nxt_to = 1'b1;
      nxt_state = IWHC_START;
      nxt_scnt = '0;
      if (state_ff == IWHC_HALT) begin
        nxt_warm = 1'b1;
      end else begin
        nxt_crst = 1'b1;
      end
    end
    if (rst_low) begin
      nxt_crst = 1'b1;
      nxt_state = IWHC_START;
      nxt_scnt = '0;
    end
  end

  always_comb begin
    case (addr_i)
      INTC_LOW_ADDR: nxt_rd = {1'b0, flags_ff[2:0], en_ff[2:0], gie_ff};
      INTC_HIGH_ADDR: nxt_rd = {3'h0, flags_ff[SRC_SER], 3'h0, en_ff[SRC_SER]};
      default: nxt_rd = 8'h00;
    endcase
    nxt_run = nxt_state == IWHC_RUN;
    nxt_halt = nxt_state == IWHC_HALT;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_ff <= INTC_RESET[3:0];
      en_ff <= INTC_RESET[3:0];
      gie_ff <= 1'b0;
      mask_ff <= 4'h0;
      call_ff <= 1'b0;
      vec_ff <= 8'h00;
      seen1_ff <= 1'b0;
      seen2_ff <= 1'b0;
      state_ff <= IWHC_START;
      scnt_ff <= 11'h000;
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
      crst_ff <= 1'b0;
      warm_ff <= 1'b0;
      div_ff <= 2'h0;
      oscillator_pin_two_ff <= 1'b0;
      rd_ff <= 8'h00;
      run_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      en_ff <= nxt_en;
      gie_ff <= nxt_gie;
      mask_ff <= nxt_mask;
      call_ff <= nxt_call;
      vec_ff <= nxt_vec;
      seen1_ff <= nxt_seen1;
      seen2_ff <= nxt_seen2;
      state_ff <= nxt_state;
      scnt_ff <= nxt_scnt;
      to_ff <= nxt_to;
      pdf_ff <= nxt_pdf;
      crst_ff <= nxt_crst;
      warm_ff <= nxt_warm;
      div_ff <= nxt_div;
      oscillator_pin_two_ff <= nxt_oscillator_pin_two;
      rd_ff <= nxt_rd;
      run_ff <= nxt_run;
      halt_ff <= nxt_halt;
    end
  end

  assign rd_data_o = rd_ff;
  assign int_call_o = call_ff;
  assign int_vector_o = vec_ff;
  assign running_o = run_ff;
  assign halted_o = halt_ff;
  assign chip_reset_o = crst_ff;
  assign warm_reset_o = warm_ff;
  assign oscillator_pin_two_o = oscillator_pin_two_ff;
  assign timeout_flag_o = to_ff;
  assign power_down_flag_o = pdf_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_call_on_phase: assert property (int_call_o |-> $past(second_phase_clock_i) && $past(gie_ff))
    else $error("call not aligned to a second-phase pulse");
  a_masked_no_call: assert property (!gie_ff || stack_full_i |=> !int_call_o)
    else $error("call while masked or stack full");
  a_ext_wins: assert property (ack && pend[SRC_EXT] |=> int_vector_o == VEC_EXT && !gie_ff)
    else $error("external request lost priority");
  a_ser_vector: assert property (ack && pend == 4'h8 && !return_from_interrupt_i && !rst_low
                                 |=> int_vector_o == VEC_SER && !gie_ff)
    else $error("serial request not vectored to 10H");
  a_serial_flag_set: assert property (own_address_matched_i && !rst_low && !ovf |=> flags_ff[SRC_SER])
    else $error("serial flag missed an event");
  a_flag_held: assert property (flags_ff[SRC_EXT] && !ack && !wr_low && !rst_low && !ovf
                                |=> flags_ff[SRC_EXT])
    else $error("external flag dropped by itself");
  a_return_from_interrupt_enables: assert property (return_from_interrupt_i && !rst_low && !ovf |=> gie_ff)
    else $error("return-from-interrupt left global enable clear");
  a_high_zero_bits: assert property (addr_i == INTC_HIGH_ADDR |=> rd_data_o[3:1] == 3'h0 && rd_data_o[7:5] == 3'h0)
    else $error("reserved high bits read nonzero");
  a_halt_flags: assert property (halt_entry && !ovf && !guard_clear |=> power_down_flag_o && !timeout_flag_o ##1 halted_o)
    else $error("halt entry flags wrong");
  a_warm_in_halt: assert property (ovf && state_ff == IWHC_HALT && !rst_low |=> warm_reset_o && !chip_reset_o && timeout_flag_o)
    else $error("halt overflow not a warm reset");
  a_masked_no_wake: assert property (state_ff == IWHC_HALT && (flags_ff & ~mask_ff) == 4'h0 && !(|(fall[7:0] & opt_port_wake_i))
                                     && !ovf && !rst_low |=> state_ff == IWHC_HALT)
    else $error("pre-set flag woke the device");
  c_serial_call: cover property (int_call_o && int_vector_o == VEC_SER);
  c_port_wake: cover property (state_ff == IWHC_HALT && |(fall[7:0] & opt_port_wake_i));
  c_warm_reset: cover property (warm_reset_o);
  c_two_clear: cover property (opt_two_clear_i && guard_clear);
endmodule
`default_nettype wire

//--- iwhc_core_model.sv
// Core sequencer model: phase-two service pulses, stack depth, return strobes.
// Assumes int_call_i is a one-cycle pulse on clk_i; fill_i forces a full stack.
`timescale 1ns/100ps
`default_nettype none
module iwhc_core_model import iwhc_pkg::*; #(
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic int_call_i,
  input wire logic auto_ret_i,
  input wire logic fill_i,
  output logic second_phase_clock_o,
  output logic stack_full_o,
  output logic return_from_interrupt_o
);
  logic [1:0] phase_ff;
  int depth_ff;
  logic owed_ff;
  // Outputs move on the falling edge, clear of the sampling edge
  always @(negedge clk_i) begin
    if (reset_i) begin
      phase_ff <= 2'h0;
      depth_ff <= 0;
      owed_ff <= 1'b0;
      second_phase_clock_o <= 1'b0;
      return_from_interrupt_o <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      second_phase_clock_o <= (phase_ff == 2'h3);
      return_from_interrupt_o <= 1'b0;
      if (int_call_i) begin
        depth_ff <= depth_ff + 1;
        owed_ff <= 1'b1;
      end else if (owed_ff && auto_ret_i) begin
        // No return strobe while auto_ret_i is held low; the service stays open until it rises
        return_from_interrupt_o <= 1'b1;
        depth_ff <= depth_ff - 1;
        owed_ff <= 1'b0;
      end
    end
  end
  assign stack_full_o = fill_i || (depth_ff >= DEPTH);
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the interrupt, watchdog and halt supervisor.
// Assumes the core model drives service pulses, stack state and returns.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import iwhc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_en = 1'b0;
  logic ext_n = 1'b1;
  logic rst_pin_n = 1'b1;
  logic gosc = 1'b0;
  logic g_en = 1'b0;
  logic two_clr = 1'b1;
  logic auto_ret = 1'b0;
  logic fill = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] port_a = 8'hff;
  logic [7:0] strb = 8'h00;
  logic [7:0] rdata, vec;
  logic sp2, sfull, return_from_interrupt, call, run, halted, chip_rst, warm_rst, oscillator_pin_two, to_f, pd_f, prev;
  int err_total = 0;
  int n_tests = 0;
  int calls = 0;
  int resets = 0;
  int warms = 0;
  int rises;
  logic [7:0] vecs [$];

  always #10 clk_i = ~clk_i;
  // Free-running watchdog oscillator, one tick per four system clocks
  always #40 gosc = ~gosc;

  // Sampled on the falling edge, clear of the edge that launches the flops
  always @(negedge clk_i) begin
    if (call === 1'b1) begin
      calls++;
      vecs.push_back(vec);
    end
    if (chip_rst === 1'b1 && !reset_i) resets++;
    if (warm_rst === 1'b1 && !reset_i) warms++;
  end

  iwhc_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wr_en_i(wr_en),
    .wdata_i(wdata), .rd_data_o(rdata), .second_phase_clock_i(sp2), .stack_full_i(sfull),
    .return_from_interrupt_i(return_from_interrupt), .halt_exec_i(strb[0]), .single_guard_clear_i(strb[1]),
    .first_guard_clear_i(strb[2]), .second_guard_clear_i(strb[3]),
    .timer_overflow_i(strb[4]), .converter_done_i(strb[5]),
    .own_address_matched_i(strb[6]), .byte_done_i(strb[7]), .external_int_n_i(ext_n),
    .external_reset_pin_n_i(rst_pin_n), .port_a_i(port_a), .guard_osc_i(gosc),
    .opt_rc_osc_i(1'b1), .opt_guard_enable_i(g_en), .opt_guard_src_osc_i(1'b1),
    .opt_guard_osc_enable_i(1'b1), .opt_guard_ratio_i(2'h0), .opt_two_clear_i(two_clr),
    .opt_port_wake_i(8'h04), .int_call_o(call), .int_vector_o(vec), .running_o(run),
    .halted_o(halted), .chip_reset_o(chip_rst), .warm_reset_o(warm_rst),
    .oscillator_pin_two_o(oscillator_pin_two), .timeout_flag_o(to_f), .power_down_flag_o(pd_f));

  iwhc_core_model core (.clk_i(clk_i), .reset_i(reset_i), .int_call_i(call),
    .auto_ret_i(auto_ret), .fill_i(fill), .second_phase_clock_o(sp2),
    .stack_full_o(sfull), .return_from_interrupt_o(return_from_interrupt));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_i);
    wr_en = 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr = a;
    cyc(2);
    check(name, exp, rdata);
  endtask

  task automatic pulse(input int i);
    @(negedge clk_i);
    strb[i] = 1'b1;
    @(negedge clk_i);
    strb[i] = 1'b0;
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    while (run !== 1'b1 && k < 1200) begin
      @(negedge clk_i);
      k++;
    end
    check("running", 8'h01, {7'h0, run});
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge clk_i);
    err_total++;
    summarize();
  end

  initial begin
    cyc(16);
    reset_i = 1'b0;
    wait_run();
    rd_chk("low reset", INTC_LOW_ADDR, INTC_RESET);
    rd_chk("high reset", INTC_HIGH_ADDR, INTC_RESET);
    wr(INTC_HIGH_ADDR, 8'hef);
    rd_chk("high unused bits", INTC_HIGH_ADDR, 8'h01);
    wr(8'h20, 8'h5a);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(INTC_LOW_ADDR, 8'h0e);
    rd_chk("low enables", INTC_LOW_ADDR, 8'h0e);
    pulse(4);
    pulse(5);
    pulse(6);
    ext_n = 1'b0;
    cyc(10);
    rd_chk("low flags", INTC_LOW_ADDR, 8'h7e);
    rd_chk("high flag", INTC_HIGH_ADDR, 8'h11);
    cyc(20);
    check("masked calls", 8'h00, calls[7:0]);
    fill = 1'b1;
    wr(INTC_LOW_ADDR, 8'h7f);
    cyc(20);
    check("stack full calls", 8'h00, calls[7:0]);
    fill = 1'b0;
    cyc(10);
    check("first call", 8'h01, calls[7:0]);
    check("first vector", VEC_EXT, vec);
    rd_chk("after call", INTC_LOW_ADDR, 8'h6e);
    cyc(20);
    check("held calls", 8'h01, calls[7:0]);
    auto_ret = 1'b1;
    wr(INTC_LOW_ADDR, 8'h6f);
    cyc(60);
    check("chained calls", 8'h04, calls[7:0]);
    for (int i = 1; i < 4; i++) begin
      check("vector order", VECTORS[i], vecs[i]);
    end
    rd_chk("low done", INTC_LOW_ADDR, 8'h0f);
    rd_chk("high done", INTC_HIGH_ADDR, 8'h01);
    ext_n = 1'b1;
    rises = 0;
    prev = oscillator_pin_two;
    repeat (16) begin
      @(negedge clk_i);
      if (oscillator_pin_two === 1'b1 && prev === 1'b0) rises++;
      prev = oscillator_pin_two;
    end
    check("clock by four", 8'h04, rises[7:0]);
    wr(INTC_LOW_ADDR, 8'h00);
    pulse(0);
    cyc(3);
    check("power down flag", 8'h01, {7'h0, pd_f});
    check("timeout flag", 8'h00, {7'h0, to_f});
    cyc(50);
    check("halted", 8'h01, {7'h0, halted});
    port_a[2] = 1'b0;
    cyc(12);
    check("woken", 8'h00, {7'h0, halted});
    wait_run();
    check("port wake calls", 8'h04, calls[7:0]);
    port_a = 8'hff;
    g_en = 1'b1;
    // Stage clears every 3000 ticks keep the count below the overflow point
    repeat (3) begin
      cyc(12000);
      pulse(2);
      pulse(3);
    end
    check("no overflow", 8'h00, resets[7:0]);
    check("clear drops power down", 8'h00, {7'h0, pd_f});
    repeat (3) begin
      cyc(12000);
      pulse(2);
    end
    check("overflow reset", 8'h01, resets[7:0]);
    check("timeout set", 8'h01, {7'h0, to_f});
    check("no warm reset in run", 8'h00, warms[7:0]);
    wait_run();
    summarize();
  end
endmodule
`default_nettype wire
